// *** design/aid_defines.svh ***
// Constants of the analog input diagnostic record: byte indices, fields,
// fixed values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH

// Byte index of each field within the 20-byte record.
`define AID_IDX_DIAG_SUMMARY 5'h00
`define AID_IDX_MODULE_CLASS 5'h01
`define AID_IDX_RSVD_C 5'h02
`define AID_IDX_RSVD_D 5'h03
`define AID_IDX_CHANNEL_KIND 5'h04
`define AID_IDX_DIAG_BITS 5'h05
`define AID_IDX_CHANNEL_COUNT 5'h06
`define AID_IDX_GROUP_ERRORS 5'h07
`define AID_IDX_CHAN_ERR_BASE 5'h08
`define AID_IDX_SPARE_ERR_BASE 5'h0c
`define AID_IDX_TIMESTAMP_BASE 5'h10
`define AID_IDX_LAST 5'h13

// Summary byte fields.
`define AID_SUM_MODULE_FAIL 0
`define AID_SUM_INTERNAL 1
`define AID_SUM_EXTERNAL 2
`define AID_SUM_CHANNEL 3
`define AID_SUM_AUX_MISSING 4
`define AID_SUM_PARAM 7

// Module information byte fields.
`define AID_MOD_CLASS_ANALOG 4'h5
`define AID_MOD_CHAN_INFO 4

// Channel error byte fields.
`define AID_CH_PARAM 0
`define AID_CH_UNDER 6
`define AID_CH_OVER 7

// Fixed record values.
`define AID_DIAG_BITS_VAL 8'h08
`define AID_CHANNEL_COUNT_VAL 8'h04
`define AID_NUM_CH 4

// Microsecond ticker timing.
`define AID_CLK_MHZ 100
`define AID_TICK_NS 1000
`define AID_CLK_PERIOD_NS 10
`define AID_TICK_CYCLES (`AID_TICK_NS / `AID_CLK_PERIOD_NS)

`endif

// *** design/aid_pkg.sv ***
// Types of the analog input diagnostic record.
// Assumes aid_defines.svh supplies the numeric constants.
package aid_pkg;

  typedef logic [7:0] aid_byte_t;

  // Channel type codes carried in the channel kind byte.
  typedef enum logic [6:0] {
    AID_KIND_DIG_IN = 7'h70,
    AID_KIND_ANA_IN = 7'h71,
    AID_KIND_DIG_OUT = 7'h72,
    AID_KIND_ANA_OUT = 7'h73,
    AID_KIND_ANA_INOUT = 7'h74,
    AID_KIND_COUNTER = 7'h76
  } aid_kind_t;

endpackage

// *** design/aid_diag_record.sv ***
// Diagnostic record of a four-channel analog input module, read bytewise.
// Assumes error inputs come from logic on clk, except the auxiliary
// supply sense, which is a pin and is synchronised here.
//
// Operation
// - Summary bits 0-2: module, internal, external faults.
// - Summary bit 3 channel error, bit 4 supply.
// - Summary bit 7 parameter error; bits 6,5 zero.
// - Module class bits 3-0 show analog pattern.
// - Module info bit 4 marks channel information.
// - Channel kind byte codes the analog input.
// - Diagnostic bits per channel reads 08h.
// - Channel count reads 04h.
// - Group error bits 0-3 follow each channel.
// - Channel byte bit 0: parameter error.
// - Channel byte bit 6 underflow, 7 overflow.
// - Diagnostic event captures ticker into timestamp.
// - Ticker starts at zero, counts microseconds.
// - Ticker wraps to zero after maximum.
// - Channel errors light their channel indicator; no interrupt.
`timescale 1ns/1ps
`include "aid_defines.svh"

module aid_diag_record (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic module_fail,
  input wire logic internal_err,
  input wire logic external_err,
  input wire logic aux_supply_missing_pin,
  input wire logic module_param_err,
  input wire logic [3:0] ch_param_err,
  input wire logic [3:0] ch_underflow,
  input wire logic [3:0] ch_overflow,
  input wire logic rd_en,
  input wire logic [4:0] rd_index,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [3:0] ch_led
);

  // Builds one channel error byte; used for the record and the indicators.
  function automatic aid_pkg::aid_byte_t chan_byte(
    input logic perr,
    input logic under,
    input logic over
  );
    aid_pkg::aid_byte_t b;
    b = 8'h00;
    b[`AID_CH_PARAM] = perr;
    b[`AID_CH_UNDER] = under;
    b[`AID_CH_OVER] = over;
    return b;
  endfunction

  logic aux_meta_q;
  logic aux_sync_q;
  logic [6:0] pre_q;
  logic [31:0] ticker_q;
  logic [31:0] stamp_q;
  logic [7:0] chan_q [0:3];
  logic [7:0] summary_q;
  logic [7:0] summary_d;
  logic [3:0] group_q;
  logic [3:0] group_d;
  logic [7:0] chan_d [0:3];
  logic event_now;
  logic any_param;

  // The supply sense is asynchronous to clk.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_meta_q <= 1'b0;
      aux_sync_q <= 1'b0;
    end else if (ce) begin
      aux_meta_q <= aux_supply_missing_pin;
      aux_sync_q <= aux_meta_q;
    end
  end

  // Prescaler and ticker; the ticker rolls over naturally at its width.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 7'h00;
      ticker_q <= 32'h0000_0000;
    end else if (ce) begin
      if (pre_q == 7'(`AID_TICK_CYCLES - 1)) begin
        pre_q <= 7'h00;
        ticker_q <= ticker_q + 32'h0000_0001;
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `AID_NUM_CH; g++) begin : g_ch
      assign chan_d[g] = chan_byte(ch_param_err[g], ch_underflow[g],
                                   ch_overflow[g]);
      assign group_d[g] = |chan_d[g];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          chan_q[g] <= 8'h00;
          ch_led[g] <= 1'b0;
        end else if (ce) begin
          chan_q[g] <= chan_d[g];
          ch_led[g] <= |chan_d[g];
        end
      end
    end
  endgenerate

  assign any_param = module_param_err | (|ch_param_err);

  always_comb begin
    summary_d = 8'h00;
    summary_d[`AID_SUM_MODULE_FAIL] = module_fail;
    summary_d[`AID_SUM_INTERNAL] = internal_err;
    summary_d[`AID_SUM_EXTERNAL] = external_err;
    summary_d[`AID_SUM_CHANNEL] = |group_d;
    summary_d[`AID_SUM_AUX_MISSING] = aux_sync_q;
    summary_d[`AID_SUM_PARAM] = any_param;
  end

  // A diagnostic event is any summary bit or channel group newly raised.
  assign event_now = |(summary_d & ~summary_q) | |(group_d & ~group_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      summary_q <= 8'h00;
      group_q <= 4'h0;
    end else if (ce) begin
      summary_q <= summary_d;
      group_q <= group_d;
    end
  end

  // The stamp holds the last event time; no interrupt is raised for it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stamp_q <= 32'h0000_0000;
    end else if (ce && event_now) begin
      stamp_q <= ticker_q;
    end
  end

  // Read port: one cycle latency; unmapped and reserved bytes read zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        unique case (rd_index)
          `AID_IDX_DIAG_SUMMARY: rd_data <= summary_q;
          `AID_IDX_MODULE_CLASS: begin
            // The four channel bytes always exist, so the info bit stands.
            rd_data <= {3'h0, 1'b1, `AID_MOD_CLASS_ANALOG};
          end
          `AID_IDX_CHANNEL_KIND: begin
            rd_data <= {1'b0, aid_pkg::AID_KIND_ANA_IN};
          end
          `AID_IDX_DIAG_BITS: rd_data <= `AID_DIAG_BITS_VAL;
          `AID_IDX_CHANNEL_COUNT: rd_data <= `AID_CHANNEL_COUNT_VAL;
          `AID_IDX_GROUP_ERRORS: rd_data <= {4'h0, group_q};
          5'h08, 5'h09, 5'h0a, 5'h0b: rd_data <= chan_q[rd_index[1:0]];
          5'h10, 5'h11, 5'h12, 5'h13: rd_data <= stamp_q[rd_index[1:0]*8 +: 8];
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

endmodule // aid_diag_record

// *** test/aid_host_model.sv ***
// Bus coupler side: reads one record byte at a time.
// Assumes a fixed one-cycle answer from the record.
`timescale 1ns/1ps
module aid_host_model (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_en,
  output logic [4:0] rd_index
);
  initial begin
    rd_en = 1'b0;
    rd_index = 5'h1f;
  end
  // The released index is inverted so a stale value cannot pass for a read.
  task automatic read(input logic [4:0] i, output logic [7:0] v,
    output logic vl);
    @(negedge clk);
    rd_en = 1'b1;
    rd_index = i;
    @(negedge clk);
    rd_en = 1'b0;
    rd_index = ~i;
    v = rd_data;
    vl = rd_valid;
  endtask
endmodule // aid_host_model

// *** test/aid_diag_record_chk.sv ***
// Checker of the record bytes and channel indicators.
// Sees only the ports of aid_diag_record; bound below.
`timescale 1ns/1ps
module aid_diag_record_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic module_fail,
  input wire logic internal_err,
  input wire logic external_err,
  input wire logic [3:0] ch_param_err,
  input wire logic [3:0] ch_underflow,
  input wire logic [3:0] ch_overflow,
  input wire logic rd_en,
  input wire logic [4:0] rd_index,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] ch_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic run_q;
  wire logic [3:0] err = ch_param_err | ch_underflow | ch_overflow;
  // Live-input checks need a full enabled cycle after reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) run_q <= 1'b0;
    else run_q <= ce;
  end
  sequence rd_at(logic [4:0] i);
    ce && rd_en && rd_index == i;
  endsequence
  sequence fresh_rd(logic [4:0] i);
    run_q ##0 rd_at(i);
  endsequence
  kind_code_a: assert property (rd_at(5'h04) |=> rd_data == 8'h71)
    else $error("channel kind byte wrong");
  bit_count_a: assert property (rd_at(5'h05) |=> rd_data == 8'h08)
    else $error("diagnostic bit count wrong");
  chan_count_a: assert property (rd_at(5'h06) |=> rd_data == 8'h04)
    else $error("channel count wrong");
  spare_zero_a: assert property (ce && rd_en && (rd_index > 5'h13 ||
    rd_index inside {5'h02, 5'h03, [5'h0c:5'h0f]}) |=> rd_data == 8'h00)
    else $error("reserved byte not zero");
  summary_low_a: assert property (fresh_rd(5'h00) |=> rd_data[2:0] ==
    $past({external_err, internal_err, module_fail}, 2))
    else $error("summary fault bits wrong");
  group_err_a: assert property (fresh_rd(5'h07) |=>
    rd_data == {4'h0, $past(err, 2)}) else $error("group byte wrong");
  chan_err_a: assert property (fresh_rd(5'h08) |=>
    rd_data == {$past(ch_overflow[0], 2), $past(ch_underflow[0], 2),
    5'h00, $past(ch_param_err[0], 2)}) else $error("channel byte wrong");
  led_follow_a: assert property (ce |=> ch_led == $past(err))
    else $error("channel indicator wrong");
endmodule // aid_diag_record_chk
bind aid_diag_record aid_diag_record_chk chk_i (.clk, .resetn, .ce,
  .module_fail, .internal_err, .external_err, .ch_param_err, .ch_underflow,
  .ch_overflow, .rd_en, .rd_index, .rd_data, .ch_led);

// *** test/analog_input_diag_record_bench.sv ***
// Testbench of the diagnostic record, self-checking.
// Assumes the record answers a read exactly one cycle later.
`timescale 1ns/1ps
module analog_input_diag_record_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic aux_supply_missing_pin = 1'b0;
  logic module_fail, internal_err, external_err, module_param_err;
  logic [3:0] ch_param_err, ch_underflow, ch_overflow, ch_led;
  logic rd_en, rd_valid, rv;
  logic ce = 1'b1;
  logic [4:0] rd_index;
  logic [7:0] rd_data, d;
  logic [15:0] st = 16'h0000;
  int mismatches = 0;
  int check_count = 0;
  // Row: stimulus, byte index, expected byte.
  logic [31:0] rows [21] = '{32'h80000001, 32'h40000002, 32'h20000004,
    32'h10000080, 32'h00020008, 32'h00020702, 32'h00020980, 32'h00200940,
    32'h08000b01, 32'h08000088, 32'h00010115, 32'h00000471, 32'h00000508,
    32'h00000604, 32'h0f0f0881, 32'h0f0f0088, 32'h0f0f070f, 32'h0f0f0c00,
    32'h0f0f0200, 32'h0f0f1400, 32'h00f00a40};
  assign {module_fail, internal_err, external_err, module_param_err,
    ch_param_err, ch_underflow, ch_overflow} = st;
  aid_diag_record dut (.clk, .resetn, .ce(ce), .module_fail, .internal_err,
    .external_err, .aux_supply_missing_pin, .module_param_err, .ch_param_err,
    .ch_underflow, .ch_overflow, .rd_en, .rd_index, .rd_data, .rd_valid,
    .ch_led);
  aid_host_model host (.clk, .rd_valid, .rd_data, .rd_en, .rd_index);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    logic v;
    host.read(i, d, v);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk("rd_data", e, d);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    foreach (rows[k]) begin
      st = rows[k][31:16];
      rd(rows[k][12:8], rows[k][7:0]);
      chk("ch_led", {4'h0, st[11:8] | st[7:4] | st[3:0]}, {4'h0, ch_led});
    end
    st = 16'h0000;
    aux_supply_missing_pin = 1'b1;
    repeat (3) @(negedge clk);
    rd(5'h00, 8'h10);
    aux_supply_missing_pin = 1'b0;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rd(5'h00, 8'h00);
    rd(5'h01, 8'h15);
    repeat (250) @(negedge clk);
    st = 16'h0001;
    rd(5'h10, 8'h02);
    rd(5'h11, 8'h00);
    rd(5'h13, 8'h00);
    // A frozen record answers no read and keeps its indicators.
    @(negedge clk);
    ce = 1'b0;
    st = 16'h0000;
    host.read(5'h07, d, rv);
    chk("rd_valid", 8'h00, {7'h00, rv});
    chk("ch_led", 8'h01, {4'h0, ch_led});
    ce = 1'b1;
    rd(5'h07, 8'h00);
    complete_run();
  end
endmodule // analog_input_diag_record_bench
